// >>> rtl/lcdhi_pkg.sv
package lcdhi_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 5;
    localparam int INSTR_EXEC_NS  = 26000;
    localparam int CLEAR_EXEC_NS  = 1500000;
    // Busy times are longest times: round down
    localparam int INSTR_EXEC_CYC = INSTR_EXEC_NS / CLK_PERIOD_NS;
    localparam int CLEAR_EXEC_CYC = CLEAR_EXEC_NS / CLK_PERIOD_NS;
    localparam int BUSY_W         = 19;

    // ------------------------------------------------------------
    // Bus widths and pin groups
    // ------------------------------------------------------------
    localparam int BUS_W    = 8;
    localparam int NIB_W    = 4;
    localparam int AC_W     = 7;
    localparam int SER_BITS = 8;
    localparam int SER_CW   = 3;
    // e, rs, rw, serial select, two bias straps, bus lines
    localparam int SYNC_W   = 6 + BUS_W;

    localparam logic [7:0] OE_ALL   = 8'hFF;
    localparam logic [7:0] OE_UPPER = 8'hF0;
    localparam logic [7:0] OE_NONE  = 8'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [6:0] AC_ZERO  = 7'h00;
    localparam logic [6:0] AC_ONE   = 7'h01;
    localparam logic [2:0] SER_LAST = 3'h7;

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR   = 8'h01;
    localparam logic [6:0] HOME_TOP7   = 7'h01;
    localparam logic [2:0] FSET_TOP3   = 3'h1;
    localparam int         FSET_DL_BIT = 4;
    localparam int         FSET_IS_BIT = 0;
    localparam logic [1:0] CGRAM_TOP2  = 2'h1;
    localparam logic [3:0] PWR_TOP4    = 4'h5;
    localparam int         PWR_BON_BIT = 2;
    localparam int         DDRAM_BIT   = 7;

    // ------------------------------------------------------------
    // Nibble phase of a 4-bit transfer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        NIB_HIGH = 2'b01,
        NIB_LOW  = 2'b10
    } lcdhi_nib_e;

endpackage : lcdhi_pkg

// >>> rtl/lcdhi_sync.sv
`timescale 1ns/1ps
`default_nettype none

module lcdhi_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_reg <= RST_VAL;
            q_reg    <= RST_VAL;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;

endmodule : lcdhi_sync

`default_nettype wire

// >>> rtl/lcdhi_ser_rx.sv
`timescale 1ns/1ps
`default_nettype none

module lcdhi_ser_rx
    import lcdhi_pkg::*;
(
    input  wire logic        link_sclk,
    input  wire logic        nrst,
    input  wire logic        chip_select_n,
    input  wire logic        serial_data,
    input  wire logic        register_select,
    output logic      [7:0]  rx_byte,
    output logic             rx_rs,
    output logic             rx_toggle
);

    // ------------------------------------------------------------
    // Bit counter, cleared by the frame's own chip select
    // ------------------------------------------------------------
    logic [SER_CW-1:0] cnt_reg;
    logic [SER_CW-1:0] cnt_next;
    logic [6:0]        shift_reg;
    logic [6:0]        shift_next;

    always_comb begin
        cnt_next   = SER_CW'(cnt_reg + 1'b1);
        shift_next = {shift_reg[5:0], serial_data};
    end

    // Clock stops between frames, so chip select ends the frame
    always_ff @(posedge link_sclk or posedge chip_select_n
                or negedge nrst) begin
        if (!nrst || chip_select_n) begin
            cnt_reg   <= '0;
            shift_reg <= '0;
        end else begin
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
        end
    end

    // ------------------------------------------------------------
    // Completed byte; held until the next one, flagged by a toggle
    // ------------------------------------------------------------
    logic [7:0] byte_reg;
    logic [7:0] byte_next;
    logic       rs_reg;
    logic       rs_next;
    logic       tog_reg;
    logic       tog_next;

    always_comb begin
        byte_next = byte_reg;
        rs_next   = rs_reg;
        tog_next  = tog_reg;
        if (cnt_reg == SER_LAST) begin
            byte_next = {shift_reg, serial_data};
            rs_next   = register_select;
            tog_next  = ~tog_reg;
        end
    end

    always_ff @(posedge link_sclk or negedge nrst) begin
        if (!nrst) begin
            byte_reg <= '0;
            rs_reg   <= 1'b0;
            tog_reg  <= 1'b0;
        end else begin
            byte_reg <= byte_next;
            rs_reg   <= rs_next;
            tog_reg  <= tog_next;
        end
    end

    assign rx_byte   = byte_reg;
    assign rx_rs     = rs_reg;
    assign rx_toggle = tog_reg;

    // Checked at the next frame's first edge, so chip select may rise
    a_ser_msb_first: assert property (
        @(posedge link_sclk) disable iff (!nrst)
        (cnt_reg == SER_LAST) |=>
            (byte_reg == $past({shift_reg, serial_data})))
        else $error("serial byte not assembled msb first");

    a_ser_eighth: assert property (
        @(posedge link_sclk) disable iff (!nrst || chip_select_n)
        (cnt_reg != SER_LAST) |=> (tog_reg == $past(tog_reg)))
        else $error("serial byte flagged before eighth bit");

endmodule : lcdhi_ser_rx

`default_nettype wire

// >>> rtl/lcdhi_top.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - In 4-bit mode only the upper four bus lines carry data; the lower are ignored and never driven.
// - In 4-bit mode a byte is complete only after two nibble transfers and is acted on as a whole.
// - In 4-bit mode the high nibble goes first and the low nibble second, for writes and reads.
// - In 4-bit mode a status read takes two nibble transfers returning busy flag and address counter.
// - In 8-bit mode every byte moves on all eight bus lines in one transfer.
// - In serial mode only the top bus line is used, for serial data; the rest stay idle.
// - A serial byte is eight bits, most significant first, data set up then clock pulsed.
// - The voltage booster may run only when both bias option straps are low.
module lcdhi_top
    import lcdhi_pkg::*;
#(
    parameter int INSTR_CYC = INSTR_EXEC_CYC,
    parameter int CLEAR_CYC = CLEAR_EXEC_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        hardware_reset_n,
    input  wire logic        enable_strobe,
    input  wire logic        register_select,
    input  wire logic        read_write,
    input  wire logic        serial_select,
    input  wire logic        bias_option_a,
    input  wire logic        bias_option_b,
    input  wire logic [7:0]  bus_in,
    output logic      [7:0]  bus_out,
    output logic      [7:0]  bus_oe,
    input  wire logic        link_sclk,
    input  wire logic        chip_select_n,
    output logic             cmd_valid,
    output logic      [7:0]  cmd_byte,
    output logic             cmd_is_data,
    output logic             busy,
    output logic      [6:0]  addr_counter,
    output logic             four_bit_mode,
    output logic             instruction_table_select,
    output logic             booster_enable
);

    // ------------------------------------------------------------
    // Pin synchronisers and internal reset
    // ------------------------------------------------------------
    logic              hw_rst_s;
    logic              rst_n;
    logic [SYNC_W-1:0] pin_s;
    logic              e_s;
    logic              rs_s;
    logic              rw_s;
    logic              ser_sel_s;
    logic              bias_a_s;
    logic              bias_b_s;
    logic [BUS_W-1:0]  bus_s;

    lcdhi_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_rst (
        .clk  (clk),
        .nrst (nrst),
        .d    (hardware_reset_n),
        .q    (hw_rst_s)
    );

    lcdhi_sync #(.WIDTH(SYNC_W)) u_sync_pins (
        .clk  (clk),
        .nrst (nrst),
        .d    ({enable_strobe, register_select, read_write,
                serial_select, bias_option_a, bias_option_b, bus_in}),
        .q    (pin_s)
    );

    assign rst_n = nrst & hw_rst_s;
    assign {e_s, rs_s, rw_s, ser_sel_s, bias_a_s, bias_b_s, bus_s} = pin_s;

    // ------------------------------------------------------------
    // Serial receiver on the link clock
    // ------------------------------------------------------------
    logic [7:0] rx_byte;
    logic       rx_rs;
    logic       rx_toggle;
    logic       tog_s;

    lcdhi_ser_rx u_ser_rx (
        .link_sclk       (link_sclk),
        .nrst            (rst_n),
        .chip_select_n   (chip_select_n),
        .serial_data     (bus_in[7]),
        .register_select (register_select),
        .rx_byte         (rx_byte),
        .rx_rs           (rx_rs),
        .rx_toggle       (rx_toggle)
    );

    lcdhi_sync #(.WIDTH(1)) u_sync_tog (
        .clk  (clk),
        .nrst (nrst),
        .d    (rx_toggle),
        .q    (tog_s)
    );

    // ------------------------------------------------------------
    // Host port state
    // ------------------------------------------------------------
    logic              e_prev_reg,  e_prev_next;
    logic              tog_prev_reg, tog_prev_next;
    lcdhi_nib_e        phase_reg,   phase_next;
    logic [NIB_W-1:0]  hold_reg,    hold_next;
    logic              dl8_reg,     dl8_next;
    logic              is_reg,      is_next;
    logic              bon_reg,     bon_next;
    logic              boost_reg,   boost_next;
    logic [AC_W-1:0]   ac_reg,      ac_next;
    logic [7:0]        data_reg,    data_next;
    logic [BUSY_W-1:0] bcnt_reg,    bcnt_next;
    logic              busy_reg,    busy_next;
    logic              valid_reg,   valid_next;
    logic [7:0]        cbyte_reg,   cbyte_next;
    logic              cdata_reg,   cdata_next;
    logic [7:0]        out_reg,     out_next;
    logic [7:0]        oe_reg,      oe_next;

    logic       par;
    logic       e_fall;
    logic       par_wr;
    logic       par_rd_end;
    logic       ser_evt;
    logic       ex_v;
    logic [7:0] ex_b;
    logic       ex_rs;
    logic [7:0] rd_byte;

    always_comb begin
        par        = ~ser_sel_s;
        e_fall     = e_prev_reg & ~e_s;
        par_wr     = par & e_fall & ~rw_s;
        par_rd_end = par & e_fall & rw_s;
        ser_evt    = ser_sel_s & (tog_s ^ tog_prev_reg);
        rd_byte    = rs_s ? data_reg : {busy_reg, ac_reg};

        e_prev_next   = e_s;
        tog_prev_next = tog_s;
        phase_next    = phase_reg;
        hold_next     = hold_reg;
        dl8_next      = dl8_reg;
        is_next       = is_reg;
        bon_next      = bon_reg;
        ac_next       = ac_reg;
        data_next     = data_reg;
        bcnt_next     = (bcnt_reg != '0) ? BUSY_W'(bcnt_reg - 1'b1) : '0;
        ex_v          = 1'b0;
        ex_b          = bus_s;
        ex_rs         = rs_s;
        out_next      = out_reg;
        oe_next       = OE_NONE;

        // Parallel write: one transfer or two nibbles
        if (par_wr) begin
            if (dl8_reg) begin
                ex_v = 1'b1;
            end else if (phase_reg == NIB_HIGH) begin
                hold_next  = bus_s[7:4];
                phase_next = NIB_LOW;
            end else begin
                ex_b       = {hold_reg, bus_s[7:4]};
                ex_v       = 1'b1;
                phase_next = NIB_HIGH;
            end
        end

        // Parallel read: a data read moves the counter once per byte
        if (par_rd_end) begin
            if (!dl8_reg) begin
                phase_next = (phase_reg == NIB_HIGH) ? NIB_LOW : NIB_HIGH;
            end
            if (rs_s && (dl8_reg || phase_reg == NIB_LOW)) begin
                ac_next = AC_W'(ac_reg + AC_ONE);
            end
        end

        // Drive the bus only while a read strobe is high
        if (par && e_s && rw_s) begin
            if (dl8_reg) begin
                out_next = rd_byte;
                oe_next  = OE_ALL;
            end else begin
                out_next = (phase_reg == NIB_HIGH)
                         ? {rd_byte[7:4], NIB_ZERO}
                         : {rd_byte[3:0], NIB_ZERO};
                oe_next  = OE_UPPER;
            end
        end

        if (ser_evt) begin
            ex_v  = 1'b1;
            ex_b  = rx_byte;
            ex_rs = rx_rs;
        end

        // Execute a completed byte
        if (ex_v) begin
            bcnt_next = BUSY_W'(INSTR_CYC);
            if (ex_rs) begin
                data_next = ex_b;
                ac_next   = AC_W'(ac_reg + AC_ONE);
            end else if (ex_b == CMD_CLEAR) begin
                ac_next   = AC_ZERO;
                bcnt_next = BUSY_W'(CLEAR_CYC);
            end else if (ex_b[7:1] == HOME_TOP7) begin
                ac_next   = AC_ZERO;
            end else if (ex_b[DDRAM_BIT]) begin
                ac_next   = ex_b[6:0];
            end else if (ex_b[7:5] == FSET_TOP3) begin
                dl8_next   = ex_b[FSET_DL_BIT];
                is_next    = ex_b[FSET_IS_BIT];
                phase_next = NIB_HIGH;
            end else if (ex_b[7:6] == CGRAM_TOP2 && !is_reg) begin
                ac_next   = {1'b0, ex_b[5:0]};
            end else if (ex_b[7:4] == PWR_TOP4 && is_reg) begin
                bon_next  = ex_b[PWR_BON_BIT];
            end
        end

        // Booster only with both straps low
        boost_next = bon_reg & ~bias_a_s & ~bias_b_s;
        busy_next  = (bcnt_next != '0);
        valid_next = ex_v;
        cbyte_next = ex_v ? ex_b  : cbyte_reg;
        cdata_next = ex_v ? ex_rs : cdata_reg;
    end

    // The toggle's previous-edge register loads the live value during reset so a
    // toggle already flipped before reset does not look like a byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            e_prev_reg   <= 1'b0;
            tog_prev_reg <= tog_s;
            phase_reg    <= NIB_HIGH;
            hold_reg     <= NIB_ZERO;
            dl8_reg      <= 1'b1;
            is_reg       <= 1'b0;
            bon_reg      <= 1'b0;
            boost_reg    <= 1'b0;
            ac_reg       <= AC_ZERO;
            data_reg     <= BYTE_ZERO;
            bcnt_reg     <= '0;
            busy_reg     <= 1'b0;
            valid_reg    <= 1'b0;
            cbyte_reg    <= BYTE_ZERO;
            cdata_reg    <= 1'b0;
            out_reg      <= BYTE_ZERO;
            oe_reg       <= OE_NONE;
        end else begin
            e_prev_reg   <= e_prev_next;
            tog_prev_reg <= tog_prev_next;
            phase_reg    <= phase_next;
            hold_reg     <= hold_next;
            dl8_reg      <= dl8_next;
            is_reg       <= is_next;
            bon_reg      <= bon_next;
            boost_reg    <= boost_next;
            ac_reg       <= ac_next;
            data_reg     <= data_next;
            bcnt_reg     <= bcnt_next;
            busy_reg     <= busy_next;
            valid_reg    <= valid_next;
            cbyte_reg    <= cbyte_next;
            cdata_reg    <= cdata_next;
            out_reg      <= out_next;
            oe_reg       <= oe_next;
        end
    end

    assign bus_out                  = out_reg;
    assign bus_oe                   = oe_reg;
    assign cmd_valid                = valid_reg;
    assign cmd_byte                 = cbyte_reg;
    assign cmd_is_data              = cdata_reg;
    assign busy                     = busy_reg;
    assign addr_counter             = ac_reg;
    assign four_bit_mode            = ~dl8_reg;
    assign instruction_table_select = is_reg;
    assign booster_enable           = boost_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_low_lines_idle: assert property (
        !dl8_reg |-> (oe_reg[3:0] == NIB_ZERO))
        else $error("lower lines driven in 4-bit mode");

    a_two_nibbles: assert property (
        (par_wr && !dl8_reg && phase_reg == NIB_HIGH) |=> !valid_reg)
        else $error("byte acted on after one nibble");

    a_nibble_order: assert property (
        (par_wr && !dl8_reg && phase_reg == NIB_LOW) |=>
            valid_reg && cbyte_reg == $past({hold_reg, bus_s[7:4]}))
        else $error("nibbles not joined high first");

    a_status_nibble: assert property (
        (par && e_s && rw_s && !rs_s && !dl8_reg
         && phase_reg == NIB_LOW) |=>
            (out_reg[7:4] == $past(ac_reg[3:0])))
        else $error("second status nibble wrong");

    a_full_byte: assert property (
        (par_wr && dl8_reg && !ser_evt) |=>
            valid_reg && cbyte_reg == $past(bus_s))
        else $error("8-bit write not taken whole");

    a_serial_quiet: assert property (
        ser_sel_s |=> (oe_reg == OE_NONE))
        else $error("bus driven in serial mode");

    a_booster_gate: assert property (
        booster_enable |-> $past(!bias_a_s && !bias_b_s))
        else $error("booster on with a bias strap high");

    a_status_byte: assert property (
        (par && e_s && rw_s && !rs_s && dl8_reg) |=>
            (out_reg == $past({busy_reg, ac_reg})))
        else $error("status byte layout wrong");

    a_busy_after: assert property (
        valid_reg |-> busy_reg ##1 busy_reg)
        else $error("busy not set while executing");

    a_serial_exec: assert property (
        ser_evt |=> valid_reg && cbyte_reg == $past(rx_byte))
        else $error("serial byte not executed");

endmodule : lcdhi_top

`default_nettype wire

// >>> verif/lcdhi_host.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host side of the parallel and serial pins
// ------------------------------------------------------------
module lcdhi_host (
    input  wire logic       clk,
    input  wire logic [7:0] dev_out,
    input  wire logic [7:0] dev_oe,
    output logic      [7:0] line,
    output logic            e,
    output logic            rs,
    output logic            rw,
    output logic            sclk,
    output logic            csn
);
    logic [7:0] hv;
    logic       hdrv;

    // Undriven lines toggle so a stale value can never pass
    assign line = (dev_oe & dev_out) | (~dev_oe & (hdrv ? hv : ~hv));

    initial begin
        {e, rs, rw, sclk, hdrv} = 5'h00;
        hv = 8'h00;
        csn = 1'b1;
    end

    task automatic wr(input logic r, input logic [7:0] v);
        @(posedge clk);
        #1 {rs, rw, hv, hdrv, e} = {r, 1'b0, v, 2'h3};
        repeat (6) @(posedge clk);
        #1 e = 1'b0;
        repeat (6) @(posedge clk);
        #1 hdrv = 1'b0;
    endtask : wr

    task automatic rd(input logic r, output logic [7:0] v,
                      output logic [7:0] o);
        @(posedge clk);
        #1 {rs, rw, e} = {r, 2'h3};
        repeat (6) @(posedge clk);
        #1 v = line;
        o = dev_oe;
        e = 1'b0;
        repeat (6) @(posedge clk);
        #1 rw = 1'b0;
    endtask : rd

    // Clock stands low between frames
    task automatic ser(input logic r, input logic [7:0] v, input int n);
        @(posedge clk);
        #1 {csn, rs, hdrv} = {1'b0, r, 1'b1};
        #20;
        for (int i = 0; i < n; i++) begin
            hv[7] = v[7-i];
            #16 sclk = 1'b1;
            #32 sclk = 1'b0;
            #16;
        end
        #40 {csn, hdrv} = 2'h2;
    endtask : ser
endmodule : lcdhi_host

`default_nettype wire

// >>> verif/lcdhi_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module lcdhi_top_bench;
    import lcdhi_pkg::*;
    logic       clk, nrst, hw_n, ssel, opa, opb;
    logic       e, rs, rw, sclk, csn, cv, isd, busy, fb, tsel, bst;
    logic [7:0] line, bo, boe, cb, v, o;
    logic [6:0] ac;
    int         error_cnt, checks_done, ncmd, n0;

    lcdhi_top #(.INSTR_CYC(20), .CLEAR_CYC(50)) lcdhi_top_inst (
        .clk(clk), .nrst(nrst), .hardware_reset_n(hw_n),
        .enable_strobe(e), .register_select(rs), .read_write(rw),
        .serial_select(ssel), .bias_option_a(opa),
        .bias_option_b(opb), .bus_in(line), .bus_out(bo),
        .bus_oe(boe), .link_sclk(sclk), .chip_select_n(csn),
        .cmd_valid(cv), .cmd_byte(cb), .cmd_is_data(isd),
        .busy(busy), .addr_counter(ac), .four_bit_mode(fb),
        .instruction_table_select(tsel), .booster_enable(bst)
    );

    lcdhi_host lcdhi_host_inst (
        .clk(clk), .dev_out(bo), .dev_oe(boe), .line(line),
        .e(e), .rs(rs), .rw(rw), .sclk(sclk), .csn(csn)
    );

    always @(posedge clk) if (cv === 1'b1) ncmd <= ncmd + 1;

    task automatic chk(input string nm, input logic [7:0] s, ex);
        checks_done++;
        if (s !== ex) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, ex, s);
        end
    endtask : chk

    task automatic idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 400) begin
            @(posedge clk);
            k++;
        end
        chk("idle", {7'h00, busy}, 8'h00);
    endtask : idle

    task automatic results;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #300000;
        error_cnt++;
        results();
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, ssel, opa, opb} = 4'h0;
        hw_n        = 1'b1;
        error_cnt   = 0;
        checks_done = 0;
        ncmd        = 0;
        repeat (4) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clk);
        chk("mode", fb, 8'h00);
        lcdhi_host_inst.wr(0, 8'h38);
        lcdhi_host_inst.wr(0, 8'h39);
        chk("byte", cb, 8'h39);
        chk("table", tsel, 8'h01);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk) #1 {opb, opa} = s[1:0];
            repeat (8) @(posedge clk);
            lcdhi_host_inst.wr(0, 8'h5E);
            chk("boost", bst, {7'h00, s == 0});
        end
        lcdhi_host_inst.wr(0, 8'h6A);
        repeat (400) @(posedge clk);
        lcdhi_host_inst.wr(0, 8'h0C);
        chk("dispon", cb, 8'h0C);
        lcdhi_host_inst.wr(0, 8'h85);
        lcdhi_host_inst.rd(0, v, o);
        chk("busyflag", v[7], 8'h01);
        chk("oe8", o, 8'hFF);
        idle();
        lcdhi_host_inst.rd(0, v, o);
        chk("status", v, 8'h05);
        lcdhi_host_inst.wr(0, 8'h01);
        repeat (30) @(posedge clk);
        chk("clrbusy", busy, 8'h01);
        idle();
        chk("ac", ac, 8'h00);
        lcdhi_host_inst.wr(0, 8'h28);
        chk("mode4", fb, 8'h01);
        n0 = ncmd;
        lcdhi_host_inst.wr(1, 8'hA3);
        chk("half", ncmd[7:0], n0[7:0]);
        lcdhi_host_inst.wr(1, 8'h5C);
        chk("whole", ncmd[7:0], n0[7:0] + 8'h01);
        chk("byte4", cb, 8'hA5);
        chk("data", isd, 8'h01);
        idle();
        lcdhi_host_inst.rd(0, v, o);
        chk("nibhi", v[7:4], 8'h00);
        chk("oe4", o, 8'hF0);
        lcdhi_host_inst.rd(0, v, o);
        chk("niblo", v[7:4], 8'h01);
        lcdhi_host_inst.rd(1, v, o);
        chk("dathi", v[7:4], 8'h0A);
        lcdhi_host_inst.rd(1, v, o);
        chk("datlo", v[7:4], 8'h05);
        chk("acinc", ac, 8'h02);
        @(posedge clk) #1 hw_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 hw_n = 1'b1;
        repeat (40) @(posedge clk);
        chk("hwrst", fb, 8'h00);
        #1 ssel = 1'b1;
        repeat (8) @(posedge clk);
        n0 = ncmd;
        lcdhi_host_inst.ser(0, 8'h55, 5);
        repeat (20) @(posedge clk);
        chk("partial", ncmd[7:0], n0[7:0]);
        lcdhi_host_inst.ser(1, 8'hC3, 8);
        repeat (20) @(posedge clk);
        chk("serbyte", cb, 8'hC3);
        chk("serdata", isd, 8'h01);
        chk("sercnt", ncmd[7:0], n0[7:0] + 8'h01);
        chk("seroe", boe, 8'h00);
        repeat (6000) @(posedge clk);
        lcdhi_host_inst.ser(0, 8'h4E, 8);
        repeat (20) @(posedge clk);
        chk("serbyte2", cb, 8'h4E);
        chk("serinst", isd, 8'h00);
        results();
    end
endmodule : lcdhi_top_bench

`default_nettype wire
